// ==== rtl/motion_regs_pkg.sv ====
// Package with register map, field layout, reset values and carrier types for the motion block
package motion_regs_pkg;
   // Register offsets on the byte register port
   localparam logic [7:0] z_accel_low_addr = 8'h12;
   localparam logic [7:0] z_accel_high_addr = 8'h13;
   localparam logic [7:0] temperature_low_addr = 8'h14;
   localparam logic [7:0] temperature_high_addr = 8'h15;
   localparam logic [7:0] aux_conv_low_addr = 8'h16;
   localparam logic [7:0] aux_conv_high_addr = 8'h17;
   localparam logic [7:0] reset_key_addr = 8'h1f;
   localparam logic [7:0] motion_threshold_low_addr = 8'h20;
   localparam logic [7:0] motion_threshold_high_addr = 8'h21;
   localparam logic [7:0] motion_sample_count_addr = 8'h22;
   localparam logic [7:0] still_threshold_low_addr = 8'h23;
   localparam logic [7:0] still_threshold_high_addr = 8'h24;
   localparam logic [7:0] still_sample_count_low_addr = 8'h25;
   localparam logic [7:0] still_sample_count_high_addr = 8'h26;

   // Values and field layout
   localparam logic [7:0] reset_key_code = 8'h52;
   localparam logic [7:0] reg_reset_value = 8'h00;
   localparam logic [7:0] write_only_read_value = 8'h00;
   localparam logic [7:0] unmapped_read_value = 8'h00;
   localparam int sample_width = 12;
   localparam int threshold_width = 11;
   localparam int threshold_high_bits = 3;
   localparam int sign_bit = 11;
   localparam int sign_copy_count = 4;
   localparam logic [sample_width-1:0] sample_reset_value = 12'h000;
   localparam logic [15:0] still_count_reset_value = 16'h0000;

   // One set of synchronous sensor results
   typedef struct packed {
      logic [sample_width-1:0] x_accel;
      logic [sample_width-1:0] y_accel;
      logic [sample_width-1:0] z_accel;
      logic [sample_width-1:0] temperature;
      logic [sample_width-1:0] aux_conv;
   } sample_set_type;

   // One access from the serial port decoder
   typedef struct packed {
      logic write;
      logic read;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_access_type;
endpackage

// ==== rtl/motion_regs.sv ====
// Data, soft reset, threshold and timer registers with activity and inactivity detection
// Summary of operation
// - Z acceleration read as 12-bit two's complement, low byte, high nibble, sign copies.
// - Temperature read as 12-bit two's complement, upper four bits follow bit 11.
// - Auxiliary converter read as 12-bit two's complement with sign copies in 15:12.
// - Writing 0x52 to the reset key clears all settings and enters standby.
// - Soft reset releases interrupt pins to high impedance, kept by bus keepers.
// - Reset key register is write-only and reads back 0x00.
// - Activity compares each axis magnitude with an unsigned 11-bit threshold.
// - Activity threshold is low byte plus bits 2:0 of high byte.
// - Inactivity compares each axis magnitude with an 11-bit threshold, split likewise.
// - Activity reported after programmed 8-bit run of samples with an axis above.
// - Activity count of zero behaves exactly as a count of one.
// - In wake-up mode one sample above threshold reports activity.
// - Inactivity reported after 16-bit run of samples with all axes below.
// - Inactivity count of zero behaves exactly as a count of one.
// - Detection sets the motion flag or the still flag in status.
`timescale 1ns/1ns
module motion_regs (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire motion_regs_pkg::reg_access_type access_in,
   input wire motion_regs_pkg::sample_set_type sample_in,
   input wire logic sample_valid_in,
   input wire logic wake_up_mode_in,
   input wire logic measure_req_in,
   input wire logic status_read_in,
   output logic [7:0] read_data_out,
   output logic motion_flag_out,
   output logic still_flag_out,
   output logic int_drive_en_out,
   output logic standby_out,
   output logic soft_reset_out
);
   import motion_regs_pkg::*;

   // Data result registers, kept at full 12-bit width
   logic [sample_width-1:0] z_accel_reg, z_accel_next;
   logic [sample_width-1:0] temperature_reg, temperature_next;
   logic [sample_width-1:0] aux_conv_reg, aux_conv_next;
   // Host setting registers, stored as written including ignored bits
   logic [7:0] motion_threshold_low_reg, motion_threshold_low_next;
   logic [7:0] motion_threshold_high_reg, motion_threshold_high_next;
   logic [7:0] motion_sample_count_reg, motion_sample_count_next;
   logic [7:0] still_threshold_low_reg, still_threshold_low_next;
   logic [7:0] still_threshold_high_reg, still_threshold_high_next;
   logic [7:0] still_sample_count_low_reg, still_sample_count_low_next;
   logic [7:0] still_sample_count_high_reg, still_sample_count_high_next;
   // Read answer and the two consecutive-sample run counters
   logic [7:0] read_data_reg, read_data_next;
   logic [7:0] motion_run_reg, motion_run_next;
   logic [15:0] still_run_reg, still_run_next;
   // Sticky flags and power state
   logic motion_flag_reg, motion_flag_next;
   logic still_flag_reg, still_flag_next;
   logic int_drive_en_reg, int_drive_en_next;
   logic standby_reg, standby_next;
   logic soft_reset_reg, soft_reset_next;

   // Decoded key write and per-sample comparison results
   logic soft_reset_hit;
   logic [threshold_width-1:0] motion_threshold;
   logic [threshold_width-1:0] still_threshold;
   logic [sample_width-1:0] x_mag, y_mag, z_mag;
   logic any_above;
   logic all_below;
   logic [7:0] motion_target;
   logic [15:0] still_target;
   logic [8:0] motion_run_inc;
   logic [16:0] still_run_inc;

   // Magnitude of a signed sample; -2048 gives 2048, which still fits 12 unsigned bits
   function automatic logic [sample_width-1:0] magnitude(input logic [sample_width-1:0] s);
      logic [sample_width-1:0] m;
      m = s;
      if (s[sign_bit]) begin
         m = sample_width'(~s + 1'b1);
      end
      return m;
   endfunction

   // Sign copies fill bits 15:12 of a result pair
   // The high byte is built at read time, so the stored result stays 12 bits
   function automatic logic [7:0] high_byte(input logic [sample_width-1:0] s);
      return {{sign_copy_count{s[sign_bit]}}, s[sample_width-1:8]};
   endfunction

   // Threshold assembly and per-sample comparisons
   always_comb begin
      // Only the exact key at the key address counts as a soft reset
      soft_reset_hit = access_in.write && (access_in.addr == reset_key_addr) &&
                       (access_in.wdata == reset_key_code);
      // Upper bits of each high threshold byte are stored but never compared
      motion_threshold = {motion_threshold_high_reg[threshold_high_bits-1:0],
                          motion_threshold_low_reg};
      still_threshold = {still_threshold_high_reg[threshold_high_bits-1:0],
                         still_threshold_low_reg};
      // Magnitudes of all three axes; both detectors watch every axis
      x_mag = magnitude(sample_in.x_accel);
      y_mag = magnitude(sample_in.y_accel);
      z_mag = magnitude(sample_in.z_accel);
      // Threshold is zero-extended to 12 bits so a 2048 magnitude compares correctly
      any_above = (x_mag > {1'b0, motion_threshold}) || (y_mag > {1'b0, motion_threshold}) ||
                  (z_mag > {1'b0, motion_threshold});
      // Equal to a threshold is neither above nor below, so such a sample breaks both runs
      all_below = (x_mag < {1'b0, still_threshold}) && (y_mag < {1'b0, still_threshold}) &&
                  (z_mag < {1'b0, still_threshold});
      // Zero counts act as one; wake-up mode forces a single sample
      if (wake_up_mode_in || (motion_sample_count_reg == 8'h00)) begin
         motion_target = 8'h01;
      end else begin
         motion_target = motion_sample_count_reg;
      end
      // Sixteen-bit inactivity target from the two count bytes
      if ({still_sample_count_high_reg, still_sample_count_low_reg} == 16'h0000) begin
         still_target = 16'h0001;
      end else begin
         still_target = {still_sample_count_high_reg, still_sample_count_low_reg};
      end
      // One extra bit so a full-length run cannot wrap before the compare
      motion_run_inc = {1'b0, motion_run_reg} + 9'h001;
      still_run_inc = {1'b0, still_run_reg} + 17'h00001;
   end

   // Next values for registers, detection and read data
   always_comb begin
      // Every register except the soft reset pulse keeps its value unless a branch below changes it
      z_accel_next = z_accel_reg;
      temperature_next = temperature_reg;
      aux_conv_next = aux_conv_reg;
      motion_threshold_low_next = motion_threshold_low_reg;
      motion_threshold_high_next = motion_threshold_high_reg;
      motion_sample_count_next = motion_sample_count_reg;
      still_threshold_low_next = still_threshold_low_reg;
      still_threshold_high_next = still_threshold_high_reg;
      still_sample_count_low_next = still_sample_count_low_reg;
      still_sample_count_high_next = still_sample_count_high_reg;
      motion_run_next = motion_run_reg;
      still_run_next = still_run_reg;
      motion_flag_next = motion_flag_reg;
      still_flag_next = still_flag_reg;
      int_drive_en_next = int_drive_en_reg;
      standby_next = standby_reg;
      // The reset pulse lasts exactly one cycle after the key write
      soft_reset_next = soft_reset_hit;
      read_data_next = read_data_reg;

      // Status read clears flags; a detection in the same cycle wins below
      if (status_read_in) begin
         motion_flag_next = 1'b0;
         still_flag_next = 1'b0;
      end
      // Leaving standby hands the interrupt pins back to their drivers
      // A soft reset in the same cycle still wins further down
      if (measure_req_in) begin
         standby_next = 1'b0;
         int_drive_en_next = 1'b1;
      end

      // Latch results and run detectors only while measuring
      if (sample_valid_in && !standby_reg) begin
         z_accel_next = sample_in.z_accel;
         temperature_next = sample_in.temperature;
         aux_conv_next = sample_in.aux_conv;
         // Activity run: at least one axis above the activity threshold
         if (any_above) begin
            if (motion_run_inc >= {1'b0, motion_target}) begin
               motion_flag_next = 1'b1;
               // Restart so a lasting condition sets the flag again after N samples
               motion_run_next = 8'h00;
            end else begin
               motion_run_next = motion_run_inc[7:0];
            end
         end else begin
            motion_run_next = 8'h00;
         end
         // Inactivity run: every axis below the inactivity threshold
         if (all_below) begin
            if (still_run_inc >= {1'b0, still_target}) begin
               still_flag_next = 1'b1;
               // Same restart after a detection as the activity run
               still_run_next = 16'h0000;
            end else begin
               still_run_next = still_run_inc[15:0];
            end
         end else begin
            still_run_next = 16'h0000;
         end
      end

      // Host writes to the setting registers
      // Data registers and the key register have no storage behind a write
      if (access_in.write) begin
         unique case (access_in.addr)
            motion_threshold_low_addr: motion_threshold_low_next = access_in.wdata;
            motion_threshold_high_addr: motion_threshold_high_next = access_in.wdata;
            motion_sample_count_addr: motion_sample_count_next = access_in.wdata;
            still_threshold_low_addr: still_threshold_low_next = access_in.wdata;
            still_threshold_high_addr: still_threshold_high_next = access_in.wdata;
            still_sample_count_low_addr: still_sample_count_low_next = access_in.wdata;
            still_sample_count_high_addr: still_sample_count_high_next = access_in.wdata;
            default: ;
         endcase
      end

      // Read mux; the answer is registered and valid the cycle after the strobe
      // Pairs are not snapshotted: a sample between two byte reads may mix them
      if (access_in.read) begin
         unique case (access_in.addr)
            z_accel_low_addr: read_data_next = z_accel_reg[7:0];
            z_accel_high_addr: read_data_next = high_byte(z_accel_reg);
            temperature_low_addr: read_data_next = temperature_reg[7:0];
            temperature_high_addr: read_data_next = high_byte(temperature_reg);
            aux_conv_low_addr: read_data_next = aux_conv_reg[7:0];
            aux_conv_high_addr: read_data_next = high_byte(aux_conv_reg);
            reset_key_addr: read_data_next = write_only_read_value;
            motion_threshold_low_addr: read_data_next = motion_threshold_low_reg;
            motion_threshold_high_addr: read_data_next = motion_threshold_high_reg;
            motion_sample_count_addr: read_data_next = motion_sample_count_reg;
            still_threshold_low_addr: read_data_next = still_threshold_low_reg;
            still_threshold_high_addr: read_data_next = still_threshold_high_reg;
            still_sample_count_low_addr: read_data_next = still_sample_count_low_reg;
            still_sample_count_high_addr: read_data_next = still_sample_count_high_reg;
            default: read_data_next = unmapped_read_value;
         endcase
      end

      // Soft reset overrides everything in the same cycle except the read answer
      if (soft_reset_hit) begin
         // Results and settings return to their power-on values
         z_accel_next = sample_reset_value;
         temperature_next = sample_reset_value;
         aux_conv_next = sample_reset_value;
         motion_threshold_low_next = reg_reset_value;
         motion_threshold_high_next = reg_reset_value;
         motion_sample_count_next = reg_reset_value;
         still_threshold_low_next = reg_reset_value;
         still_threshold_high_next = reg_reset_value;
         still_sample_count_low_next = reg_reset_value;
         still_sample_count_high_next = reg_reset_value;
         // Runs restart and flags drop, so no stale detection survives the reset
         motion_run_next = 8'h00;
         still_run_next = still_count_reset_value;
         motion_flag_next = 1'b0;
         still_flag_next = 1'b0;
         // Standby with the interrupt pins released until a new measure request
         standby_next = 1'b1;
         int_drive_en_next = 1'b0;
      end
   end

   // All state registered; power-on reset behaves like a soft reset
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         // Constants only, the same values a soft reset loads
         z_accel_reg <= sample_reset_value;
         temperature_reg <= sample_reset_value;
         aux_conv_reg <= sample_reset_value;
         motion_threshold_low_reg <= reg_reset_value;
         motion_threshold_high_reg <= reg_reset_value;
         motion_sample_count_reg <= reg_reset_value;
         still_threshold_low_reg <= reg_reset_value;
         still_threshold_high_reg <= reg_reset_value;
         still_sample_count_low_reg <= reg_reset_value;
         still_sample_count_high_reg <= reg_reset_value;
         read_data_reg <= reg_reset_value;
         motion_run_reg <= 8'h00;
         still_run_reg <= still_count_reset_value;
         motion_flag_reg <= 1'b0;
         still_flag_reg <= 1'b0;
         int_drive_en_reg <= 1'b0;
         standby_reg <= 1'b1;
         soft_reset_reg <= 1'b0;
      end else begin
         // Every register loads its next value on every edge
         z_accel_reg <= z_accel_next;
         temperature_reg <= temperature_next;
         aux_conv_reg <= aux_conv_next;
         motion_threshold_low_reg <= motion_threshold_low_next;
         motion_threshold_high_reg <= motion_threshold_high_next;
         motion_sample_count_reg <= motion_sample_count_next;
         still_threshold_low_reg <= still_threshold_low_next;
         still_threshold_high_reg <= still_threshold_high_next;
         still_sample_count_low_reg <= still_sample_count_low_next;
         still_sample_count_high_reg <= still_sample_count_high_next;
         read_data_reg <= read_data_next;
         motion_run_reg <= motion_run_next;
         still_run_reg <= still_run_next;
         motion_flag_reg <= motion_flag_next;
         still_flag_reg <= still_flag_next;
         int_drive_en_reg <= int_drive_en_next;
         standby_reg <= standby_next;
         soft_reset_reg <= soft_reset_next;
      end
   end

   // Outputs straight from flip-flops
   // No logic after the registers, so the outputs cannot glitch
   assign read_data_out = read_data_reg;
   assign motion_flag_out = motion_flag_reg;
   assign still_flag_out = still_flag_reg;
   assign int_drive_en_out = int_drive_en_reg;
   assign standby_out = standby_reg;
   assign soft_reset_out = soft_reset_reg;
endmodule

// ==== tb/motion_regs_sva.sv ====
// Checker for the motion register block, bound to its ports
`timescale 1ns/1ns
module motion_regs_sva
   import motion_regs_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire motion_regs_pkg::reg_access_type access_in,
   input wire motion_regs_pkg::sample_set_type sample_in,
   input wire logic sample_valid_in,
   input wire logic wake_up_mode_in,
   input wire logic measure_req_in,
   input wire logic status_read_in,
   input wire logic [7:0] read_data_out,
   input wire logic motion_flag_out,
   input wire logic still_flag_out,
   input wire logic int_drive_en_out,
   input wire logic standby_out,
   input wire logic soft_reset_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   // Key decode shared by several checks, so a soft reset is excluded where it wins
   logic key_addr;
   logic key_hit;
   assign key_addr = access_in.write && (access_in.addr == reset_key_addr);
   assign key_hit = key_addr && (access_in.wdata == reset_key_code);
   a_key_pulse: assert property (key_hit |=> soft_reset_out)
      else $error("soft reset pulse missing after key write");
   a_other_key: assert property (key_addr && !key_hit |=> !soft_reset_out)
      else $error("soft reset fired on a wrong key value");
   a_key_clears: assert property (soft_reset_out |-> standby_out && !int_drive_en_out
      && !motion_flag_out && !still_flag_out) else $error("soft reset state not entered");
   a_key_read: assert property (access_in.read && access_in.addr == reset_key_addr
      |=> read_data_out == write_only_read_value) else $error("key register read not zero");
   a_sign_copy: assert property (access_in.read
      && access_in.addr inside {8'h13, 8'h15, 8'h17}
      |=> read_data_out[7:4] == {4{read_data_out[3]}}) else $error("sign copies differ");
   a_motion_hold: assert property (motion_flag_out && !status_read_in && !key_hit
      |=> motion_flag_out) else $error("motion flag dropped without status read");
   a_still_hold: assert property (still_flag_out && !status_read_in && !key_hit
      |=> still_flag_out) else $error("still flag dropped without status read");
   a_motion_cause: assert property ($rose(motion_flag_out)
      |-> $past(sample_valid_in) && !$past(standby_out)) else $error("motion flag without sample");
   a_still_cause: assert property ($rose(still_flag_out)
      |-> $past(sample_valid_in) && !$past(standby_out)) else $error("still flag without sample");
   a_measure_drive: assert property (measure_req_in && !key_hit
      |=> int_drive_en_out && !standby_out) else $error("measure request not honoured");
endmodule
bind motion_regs motion_regs_sva motion_regs_sva_i (.clk_in(clk_in), .reset_in(reset_in),
   .access_in(access_in), .sample_in(sample_in), .sample_valid_in(sample_valid_in),
   .wake_up_mode_in(wake_up_mode_in), .measure_req_in(measure_req_in),
   .status_read_in(status_read_in), .read_data_out(read_data_out),
   .motion_flag_out(motion_flag_out), .still_flag_out(still_flag_out),
   .int_drive_en_out(int_drive_en_out), .standby_out(standby_out),
   .soft_reset_out(soft_reset_out));

// ==== tb/host_model.sv ====
// Host model issuing byte register accesses to the motion block
`timescale 1ns/1ns
module host_model
   import motion_regs_pkg::*;
(
   input wire logic clk_in,
   input wire logic [7:0] read_data_in,
   output motion_regs_pkg::reg_access_type access_out
);
   initial access_out = '0;
   // Idle address and data are inverted so a stale value is never mistaken for a request
   task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
      @(negedge clk_in);
      access_out = '{1'b1, 1'b0, addr, data};
      @(negedge clk_in);
      access_out = '{1'b0, 1'b0, ~addr, ~data};
   endtask
   // Answer is registered, so it has settled by the next falling edge
   task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
      @(negedge clk_in);
      access_out = '{1'b0, 1'b1, addr, 8'h00};
      @(negedge clk_in);
      access_out = '{1'b0, 1'b0, ~addr, 8'hff};
      data = read_data_in;
   endtask
endmodule

// ==== tb/motion_regs_tb_top.sv ====
// Self-checking testbench for the motion register block
`timescale 1ns/1ns
module motion_regs_tb_top;
   import motion_regs_pkg::*;
   logic clk_in, reset_in, sample_valid_in, wake_up_mode_in, measure_req_in, status_read_in;
   reg_access_type access_in;
   sample_set_type sample_in;
   logic [7:0] read_data_out;
   logic motion_flag_out, still_flag_out, int_drive_en_out, standby_out, soft_reset_out;
   int failures = 0;
   int total_checks = 0;
   logic [7:0] rd;
   motion_regs motion_regs_i (.clk_in(clk_in), .reset_in(reset_in), .access_in(access_in),
      .sample_in(sample_in), .sample_valid_in(sample_valid_in),
      .wake_up_mode_in(wake_up_mode_in), .measure_req_in(measure_req_in),
      .status_read_in(status_read_in), .read_data_out(read_data_out),
      .motion_flag_out(motion_flag_out), .still_flag_out(still_flag_out),
      .int_drive_en_out(int_drive_en_out), .standby_out(standby_out),
      .soft_reset_out(soft_reset_out));
   host_model host_model_i (.clk_in(clk_in), .read_data_in(read_data_out), .access_out(access_in));
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   // Case inequality so an unknown never passes as a match
   task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic rd_chk(input string name, input logic [7:0] addr, input logic [7:0] exp);
      host_model_i.reg_read(addr, rd);
      chk(name, {4'h0, exp}, {4'h0, rd});
   endtask
   // One sample pulse; data is inverted afterwards since it is only valid with the strobe
   task automatic send(input sample_set_type s);
      @(negedge clk_in);
      sample_in = s;
      sample_valid_in = 1'b1;
      @(negedge clk_in);
      sample_valid_in = 1'b0;
      sample_in = ~s;
   endtask
   task automatic pulse(input bit measure);
      @(negedge clk_in);
      if (measure) measure_req_in = 1'b1;
      else status_read_in = 1'b1;
      @(negedge clk_in);
      measure_req_in = 1'b0;
      status_read_in = 1'b0;
   endtask
   task automatic t_reset_map();
      for (int a = 'h12; a <= 'h27; a++) rd_chk("reset read", 8'(a), 8'h00);
   endtask
   // Read-only data register refuses a write; settings read back what was written
   task automatic t_rw();
      host_model_i.reg_write(8'h12, 8'hff);
      rd_chk("ro write", 8'h12, 8'h00);
      for (int a = 'h20; a <= 'h26; a++) host_model_i.reg_write(8'(a), 8'(a) ^ 8'ha5);
      for (int a = 'h20; a <= 'h26; a++) rd_chk("rw", 8'(a), 8'(a) ^ 8'ha5);
   endtask
   task automatic t_format();
      logic [7:0] exp [6] = '{8'h76, 8'hf8, 8'hab, 8'h07, 8'h01, 8'hf8};
      pulse(1'b1);
      send('{12'h000, 12'h000, 12'h876, 12'h7ab, 12'h801});
      for (int i = 0; i < 6; i++) rd_chk("data", 8'(8'h12 + i), exp[i]);
      pulse(1'b0);
   endtask
   // Threshold 0x100, upper bits of the high byte must be ignored
   task automatic t_motion();
      host_model_i.reg_write(8'h20, 8'h00);
      host_model_i.reg_write(8'h21, 8'hf9);
      host_model_i.reg_write(8'h22, 8'h02);
      host_model_i.reg_write(8'h23, 8'h00);
      host_model_i.reg_write(8'h24, 8'h00);
      // A sample below threshold restarts the run left over from the format test
      send('{12'h000, 12'h000, 12'h000, 12'h000, 12'h000});
      pulse(1'b0);
      send('{12'h000, 12'h000, 12'heff, 12'h000, 12'h000});
      send('{12'h100, 12'h000, 12'h000, 12'h000, 12'h000});
      send('{12'h000, 12'heff, 12'h000, 12'h000, 12'h000});
      chk("motion broken run", 0, motion_flag_out);
      send('{12'h101, 12'h000, 12'h000, 12'h000, 12'h000});
      chk("motion run", 1, motion_flag_out);
      pulse(1'b0);
      host_model_i.reg_write(8'h22, 8'h00);
      send('{12'h000, 12'h000, 12'heff, 12'h000, 12'h000});
      chk("motion count zero", 1, motion_flag_out);
      host_model_i.reg_write(8'h22, 8'h03);
      pulse(1'b0);
      wake_up_mode_in = 1'b1;
      send('{12'h000, 12'h000, 12'heff, 12'h000, 12'h000});
      chk("motion wake", 1, motion_flag_out);
      wake_up_mode_in = 1'b0;
   endtask
   // Count 0x0100 exercises the high count byte; threshold 0x50 with ignored upper bits
   task automatic t_still();
      host_model_i.reg_write(8'h20, 8'hff);
      host_model_i.reg_write(8'h21, 8'h07);
      host_model_i.reg_write(8'h23, 8'h50);
      host_model_i.reg_write(8'h24, 8'hf8);
      host_model_i.reg_write(8'h25, 8'h00);
      host_model_i.reg_write(8'h26, 8'h01);
      pulse(1'b0);
      send('{12'h04f, 12'hfb1, 12'h000, 12'h000, 12'h000});
      send('{12'h000, 12'h000, 12'h050, 12'h000, 12'h000});
      for (int i = 0; i < 255; i++) send('{12'h04f, 12'hfb1, 12'h000, 12'h000, 12'h000});
      chk("still short run", 0, still_flag_out);
      send('{12'h04f, 12'hfb1, 12'h000, 12'h000, 12'h000});
      chk("still run", 1, still_flag_out);
      host_model_i.reg_write(8'h26, 8'h00);
      pulse(1'b0);
      send('{12'h000, 12'h000, 12'h000, 12'h000, 12'h000});
      chk("still count zero", 1, still_flag_out);
   endtask
   task automatic t_soft_reset();
      host_model_i.reg_write(8'h1f, 8'h33);
      chk("wrong key", 0, soft_reset_out);
      rd_chk("kept setting", 8'h20, 8'hff);
      chk("pins driven", 1, int_drive_en_out);
      host_model_i.reg_write(8'h1f, 8'h52);
      chk("key pulse", 1, soft_reset_out);
      chk("standby", 1, standby_out);
      chk("pins released", 0, int_drive_en_out);
      rd_chk("cleared threshold", 8'h20, 8'h00);
      rd_chk("cleared count", 8'h22, 8'h00);
   endtask
   task automatic end_sim();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Watchdog: a hang counts as a mismatch and still reaches the closing report
   initial begin
      repeat (50000) @(posedge clk_in);
      failures++;
      end_sim();
   end
   initial begin
      reset_in = 1'b1;
      sample_valid_in = 1'b0;
      wake_up_mode_in = 1'b0;
      measure_req_in = 1'b0;
      status_read_in = 1'b0;
      sample_in = '0;
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      reset_in = 1'b0;
      t_reset_map();
      t_rw();
      t_format();
      t_motion();
      t_still();
      t_soft_reset();
      end_sim();
   end
endmodule
